//--- shared/wfd_pkg.sv
/*
 * Constants and types of the wake frame detector: register map, field
 * positions, reset values, receive byte carrier and the detector state.
 * Assumes a 16-bit internal register space addressed as printed.
 */
package wfd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] BMC_ADDR = 16'h0000;
    localparam logic [15:0] CFG_ADDR = 16'h0134;
    localparam logic [15:0] STS_ADDR = 16'h0135;
    localparam logic [15:0] STATION_ADDR = 16'h0136;
    localparam logic [15:0] PASSWORD_ADDR = 16'h0139;
    localparam logic [15:0] PATTERN_ADDR = 16'h0140;
    localparam int STATION_WORDS = 3;
    localparam int PASSWORD_WORDS = 3;
    localparam int PATTERN_WORDS = 32;

    localparam logic [15:0] BMC_RESET = 16'h0000;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] STS_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BMC_ISOLATE_BIT = 10;
    localparam int CFG_MAGIC_EN_BIT = 0;
    localparam int CFG_PATTERN_EN_BIT = 1;
    localparam int CFG_BCAST_EN_BIT = 2;
    localparam int CFG_UCAST_EN_BIT = 3;
    localparam int CFG_PASSWORD_EN_BIT = 4;
    localparam int CFG_GPIO_EN_BIT = 5;
    localparam int CFG_IRQ_EN_BIT = 6;
    localparam int STS_MAGIC_BIT = 0;
    localparam int STS_PATTERN_BIT = 1;
    localparam int STS_CRC_ERR_BIT = 2;

    // ------------------------------------------------------------
    // Frame constants
    // ------------------------------------------------------------
    localparam logic [7:0] SYNC_BYTE = 8'hff;
    localparam logic [2:0] SYNC_LEN = 3'h6;
    localparam logic [2:0] LAST_ADDR_BYTE = 3'h5;
    localparam logic [3:0] LAST_REP = 4'hf;
    localparam logic [2:0] LAST_PASS_BYTE = 3'h5;
    localparam logic [10:0] DEST_LEN = 11'h006;
    localparam logic [10:0] PATTERN_LEN = 11'h040;
    localparam logic [10:0] COUNT_MAX = 11'h7ff;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic sof;
        logic eof;
        logic [7:0] data;
    } wfd_rx_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } wfd_reg_req_type;

    typedef enum logic [3:0] {
        M_SEARCH = 4'b0001,
        M_ADDR = 4'b0010,
        M_PASS = 4'b0100,
        M_FOUND = 4'b1000
    } wfd_match_type;

    typedef struct packed {
        logic [15:0] bmc;
        logic [15:0] cfg;
        logic [15:0] sts;
        logic [5:0][7:0] station;
        logic [5:0][7:0] password;
        logic [63:0][7:0] pattern;
        logic [15:0] rdata;
        logic [31:0] crc;
        logic [10:0] bcnt;
        logic dst_uni;
        logic dst_bc;
        logic pat_ok;
        wfd_match_type mstate;
        logic [2:0] ff_cnt;
        logic [2:0] abyte;
        logic [3:0] arep;
        logic [2:0] pidx;
        logic irq;
        logic gpio;
    } wfd_state_type;

endpackage : wfd_pkg

//--- verilog/wfd_detector.sv
/*
 * Wake frame detector on the receive byte stream of the transceiver.
 * Assumes the receive path hands over one byte per valid cycle on mclk,
 * at any line rate, with sof on the first and eof on the last FCS byte,
 * and register access as single-cycle write or read strobes.
 */
// Behaviour
// - Detect wake frames at 1000, 100 and 10 Mb/s line rates.
// - Raise wake interrupt when a qualifying frame completes.
// - Check frame CRC; bad CRC suppresses the wake.
// - Optionally drive a general-purpose output on a wake.
// - Only frames addressed to this station or broadcast are examined.
// - Require six consecutive all-ones bytes before the addresses.
// - Require sixteen back-to-back station address copies; a break restarts search.
// - With password enabled, password must follow the sixteenth copy.
// - Sequence may start at any byte position of the frame.
// - One 64-byte configurable pattern also wakes the MAC.
// - Broadcast and unicast wake enables are independent.
// - Isolation bit 10 of basic mode control blocks the interrupt.
// - Configuration at 0x0134, status at 0x0135.
module wfd_detector (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Receive byte stream
    input wire wfd_pkg::wfd_rx_type rx_in,
    // Register access
    input wire wfd_pkg::wfd_reg_req_type reg_req,
    output logic [15:0] reg_rdata,
    // Wake indications
    output logic wake_irq,
    output logic gpio_wake
);
    import wfd_pkg::*;

    wfd_state_type s;
    wfd_state_type next_s;
    logic [15:0] sts_set;
    logic [15:0] sts_clr;
    logic crc_good;
    logic dest_ok;
    logic magic_hit;
    logic pat_hit;
    logic frame_end;

    // ------------------------------------------------------------
    // CRC-32, one byte, reflected
    // ------------------------------------------------------------
    function automatic logic [31:0] wfd_crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : wfd_crc_byte

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [10:0] cnt;
        logic [7:0] d;
        logic [2:0] ffc;
        wfd_match_type m;
        cnt = 11'h000;
        d = rx_in.data;
        ffc = 3'h0;
        m = M_SEARCH;
        next_s = s;
        sts_set = 16'h0000;
        sts_clr = 16'h0000;
        crc_good = 1'b0;
        dest_ok = 1'b0;
        magic_hit = 1'b0;
        pat_hit = 1'b0;
        frame_end = rx_in.valid & rx_in.eof;

        // Register writes
        if (reg_req.wr)
        begin
            if (reg_req.addr == BMC_ADDR)
                next_s.bmc = reg_req.wdata;
            if (reg_req.addr == CFG_ADDR)
                next_s.cfg = reg_req.wdata;
            if (reg_req.addr == STS_ADDR)
                sts_clr = reg_req.wdata;
            for (int k = 0; k < STATION_WORDS; k++)
            begin
                if (reg_req.addr == STATION_ADDR + k)
                begin
                    next_s.station[2*k] = reg_req.wdata[7:0];
                    next_s.station[2*k+1] = reg_req.wdata[15:8];
                end
            end
            for (int k = 0; k < PASSWORD_WORDS; k++)
            begin
                if (reg_req.addr == PASSWORD_ADDR + k)
                begin
                    next_s.password[2*k] = reg_req.wdata[7:0];
                    next_s.password[2*k+1] = reg_req.wdata[15:8];
                end
            end
            for (int k = 0; k < PATTERN_WORDS; k++)
            begin
                if (reg_req.addr == PATTERN_ADDR + k)
                begin
                    next_s.pattern[2*k] = reg_req.wdata[7:0];
                    next_s.pattern[2*k+1] = reg_req.wdata[15:8];
                end
            end
        end

        // Register reads, unmapped reads zero
        if (reg_req.rd)
        begin
            next_s.rdata = 16'h0000;
            if (reg_req.addr == BMC_ADDR)
                next_s.rdata = s.bmc;
            if (reg_req.addr == CFG_ADDR)
                next_s.rdata = s.cfg;
            if (reg_req.addr == STS_ADDR)
                next_s.rdata = s.sts;
            for (int k = 0; k < STATION_WORDS; k++)
                if (reg_req.addr == STATION_ADDR + k)
                    next_s.rdata = {s.station[2*k+1], s.station[2*k]};
            for (int k = 0; k < PASSWORD_WORDS; k++)
                if (reg_req.addr == PASSWORD_ADDR + k)
                    next_s.rdata = {s.password[2*k+1], s.password[2*k]};
            for (int k = 0; k < PATTERN_WORDS; k++)
                if (reg_req.addr == PATTERN_ADDR + k)
                    next_s.rdata = {s.pattern[2*k+1], s.pattern[2*k]};
        end

        // Byte processing, same path for every line rate
        if (rx_in.valid)
        begin
            cnt = rx_in.sof ? 11'h000 : s.bcnt;
            ffc = rx_in.sof ? 3'h0 : s.ff_cnt;
            m = rx_in.sof ? M_SEARCH : s.mstate;
            next_s.crc = wfd_crc_byte(rx_in.sof ? CRC_INIT : s.crc, d);
            next_s.dst_uni = rx_in.sof ? 1'b1 : s.dst_uni;
            next_s.dst_bc = rx_in.sof ? 1'b1 : s.dst_bc;
            next_s.pat_ok = rx_in.sof ? 1'b1 : s.pat_ok;
            if (cnt < DEST_LEN)
            begin
                next_s.dst_uni = next_s.dst_uni & (d == s.station[cnt[2:0]]);
                next_s.dst_bc = next_s.dst_bc & (d == SYNC_BYTE);
            end
            if (cnt < PATTERN_LEN)
                next_s.pat_ok = next_s.pat_ok & (d == s.pattern[cnt[5:0]]);
            next_s.bcnt = (cnt == COUNT_MAX) ? cnt : cnt + 11'h001;
            next_s.mstate = m;
            next_s.ff_cnt = ffc;

            // Byte-aligned search from any position
            unique case (m)
                M_SEARCH:
                begin
                    if (d == SYNC_BYTE)
                        next_s.ff_cnt = (ffc < SYNC_LEN) ? ffc + 3'h1 : SYNC_LEN;
                    else if (ffc == SYNC_LEN && d == s.station[0])
                    begin
                        next_s.mstate = M_ADDR;
                        next_s.abyte = 3'h1;
                        next_s.arep = 4'h0;
                    end
                    else
                        next_s.ff_cnt = 3'h0;
                end
                M_ADDR:
                begin
                    if (d == s.station[s.abyte])
                    begin
                        next_s.abyte = (s.abyte == LAST_ADDR_BYTE) ? 3'h0 : s.abyte + 3'h1;
                        if (s.abyte == LAST_ADDR_BYTE)
                        begin
                            next_s.arep = s.arep + 4'h1;
                            if (s.arep == LAST_REP)
                            begin
                                next_s.pidx = 3'h0;
                                next_s.mstate = s.cfg[CFG_PASSWORD_EN_BIT] ? M_PASS : M_FOUND;
                            end
                        end
                    end
                    else
                    begin
                        next_s.mstate = M_SEARCH;
                        next_s.ff_cnt = (d == SYNC_BYTE) ? 3'h1 : 3'h0;
                    end
                end
                M_PASS:
                begin
                    if (d == s.password[s.pidx])
                    begin
                        next_s.pidx = s.pidx + 3'h1;
                        if (s.pidx == LAST_PASS_BYTE)
                            next_s.mstate = M_FOUND;
                    end
                    else
                    begin
                        next_s.mstate = M_SEARCH;
                        next_s.ff_cnt = (d == SYNC_BYTE) ? 3'h1 : 3'h0;
                    end
                end
                M_FOUND:
                    next_s.mstate = M_FOUND;
                default:
                    next_s.mstate = M_SEARCH;
            endcase
        end

        // Frame end: qualify and record
        if (frame_end)
        begin
            crc_good = (next_s.crc == CRC_RESIDUE);
            dest_ok = (next_s.dst_uni & s.cfg[CFG_UCAST_EN_BIT])
                | (next_s.dst_bc & s.cfg[CFG_BCAST_EN_BIT]);
            magic_hit = dest_ok & s.cfg[CFG_MAGIC_EN_BIT] & (next_s.mstate == M_FOUND);
            pat_hit = dest_ok & s.cfg[CFG_PATTERN_EN_BIT] & next_s.pat_ok
                & (next_s.bcnt >= PATTERN_LEN);
            sts_set[STS_MAGIC_BIT] = magic_hit & crc_good;
            sts_set[STS_PATTERN_BIT] = pat_hit & crc_good;
            sts_set[STS_CRC_ERR_BIT] = (magic_hit | pat_hit) & ~crc_good;
        end

        // Set wins over a same-cycle clear
        next_s.sts = (s.sts & ~sts_clr) | sts_set;
        next_s.irq = s.cfg[CFG_IRQ_EN_BIT] & ~s.bmc[BMC_ISOLATE_BIT]
            & (s.sts[STS_MAGIC_BIT] | s.sts[STS_PATTERN_BIT]);
        next_s.gpio = s.cfg[CFG_GPIO_EN_BIT]
            & (s.sts[STS_MAGIC_BIT] | s.sts[STS_PATTERN_BIT]);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s <= '0;
            s.bmc <= BMC_RESET;
            s.cfg <= CFG_RESET;
            s.sts <= STS_RESET;
            s.crc <= CRC_INIT;
            s.mstate <= M_SEARCH;
        end
        else
            s <= next_s;
    end

    assign reg_rdata = s.rdata;
    assign wake_irq = s.irq;
    assign gpio_wake = s.gpio;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_isolate_blocks_irq: assert property (@(posedge mclk) disable iff (srst)
        s.bmc[BMC_ISOLATE_BIT] |=> !wake_irq)
        else $error("wake interrupt raised while isolated");

    a_bad_crc_silent: assert property (@(posedge mclk) disable iff (srst)
        frame_end && !crc_good |=> !$rose(s.sts[STS_MAGIC_BIT]) && !$rose(s.sts[STS_PATTERN_BIT]))
        else $error("wake status set on bad crc");

    a_magic_sets_irq: assert property (@(posedge mclk) disable iff (srst)
        frame_end && magic_hit && crc_good && s.cfg[CFG_IRQ_EN_BIT] && !s.bmc[BMC_ISOLATE_BIT]
        && !reg_req.wr |-> ##2 wake_irq)
        else $error("wake interrupt missing after magic frame");

    a_gpio_after_hit: assert property (@(posedge mclk) disable iff (srst)
        frame_end && (magic_hit || pat_hit) && crc_good && s.cfg[CFG_GPIO_EN_BIT]
        && !reg_req.wr |-> ##2 gpio_wake)
        else $error("gpio wake missing");

    a_dest_filter: assert property (@(posedge mclk) disable iff (srst)
        frame_end && !dest_ok |=> !$rose(s.sts[STS_MAGIC_BIT]) && !$rose(s.sts[STS_PATTERN_BIT]))
        else $error("wake from frame not addressed here");

    a_sync_run_first: assert property (@(posedge mclk) disable iff (srst)
        s.mstate == M_ADDR && $past(s.mstate) == M_SEARCH |-> $past(s.ff_cnt) == SYNC_LEN)
        else $error("address run entered without six sync bytes");

    a_sixteen_reps: assert property (@(posedge mclk) disable iff (srst)
        $past(s.mstate) == M_ADDR && s.mstate inside {M_PASS, M_FOUND}
        |-> $past(s.arep) == LAST_REP && $past(s.abyte) == LAST_ADDR_BYTE)
        else $error("address run left before sixteen copies");

    a_password_len: assert property (@(posedge mclk) disable iff (srst)
        $past(s.mstate) == M_PASS && s.mstate == M_FOUND |-> $past(s.pidx) == LAST_PASS_BYTE)
        else $error("password accepted short");

    a_pattern_wake: assert property (@(posedge mclk) disable iff (srst)
        frame_end && pat_hit && crc_good |=> s.sts[STS_PATTERN_BIT])
        else $error("pattern match not recorded");

endmodule : wfd_detector

//--- sim/wfd_station_model.sv
/*
 * Remote station model: sends received frames, FCS appended, byte by byte.
 * Assumes the detector samples rx_out on rising mclk.
 */
module wfd_station_model
    import wfd_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Byte stream toward the detector
    output wfd_pkg::wfd_rx_type rx_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        rx_out = '0;
    end

    // Whole bytes only, one every gap cycles; idle data never repeats the last byte
    task automatic send(input logic [7:0] q[$], input int gap, input bit bad_fcs);
        logic [31:0] c;
        c = CRC_INIT;
        foreach (q[i])
        begin
            c = c ^ {24'h0, q[i]};
            for (int k = 0; k < 8; k++)
            begin
                c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
            end
        end
        c = ~c ^ {31'h0, bad_fcs};
        for (int k = 0; k < 4; k++)
        begin
            q.push_back(c[8*k +: 8]);
        end
        foreach (q[i])
        begin
            for (int g = 1; g < gap && i > 0; g++)
            begin
                @(posedge mclk);
                #1;
                rx_out = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~q[i-1]};
            end
            @(posedge mclk);
            #1;
            rx_out = '{valid: 1'b1, sof: i == 0, eof: i == q.size() - 1, data: q[i]};
        end
        @(posedge mclk);
        #1;
        rx_out = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~q[q.size() - 1]};
    endtask : send
endmodule : wfd_station_model

//--- sim/wfd_detector_tb.sv
/*
 * Self-checking bench of the wake frame detector.
 * Assumes wfd_station_model supplies the receive stream.
 */
module wfd_detector_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import wfd_pkg::*;

    localparam logic [7:0] ST [6] = '{8'h02, 8'h3c, 8'h5d, 8'h7e, 8'h91, 8'ha4};
    localparam logic [7:0] PW [6] = '{8'h13, 8'h57, 8'h9b, 8'hc6, 8'he1, 8'h28};
    localparam logic [15:0] C_MAG = 16'h1 << CFG_MAGIC_EN_BIT;
    localparam logic [15:0] C_PAT = 16'h1 << CFG_PATTERN_EN_BIT;
    localparam logic [15:0] C_BC = 16'h1 << CFG_BCAST_EN_BIT;
    localparam logic [15:0] C_UC = 16'h1 << CFG_UCAST_EN_BIT;
    localparam logic [15:0] C_PW = 16'h1 << CFG_PASSWORD_EN_BIT;
    localparam logic [15:0] C_GP = 16'h1 << CFG_GPIO_EN_BIT;
    localparam logic [15:0] C_IR = 16'h1 << CFG_IRQ_EN_BIT;
    localparam logic [15:0] S_MAG = 16'h1 << STS_MAGIC_BIT;
    localparam logic [15:0] S_PAT = 16'h1 << STS_PATTERN_BIT;
    localparam logic [15:0] S_CRC = 16'h1 << STS_CRC_ERR_BIT;
    // Byte spacing for the three line rates
    localparam int RATE_GAP [3] = '{1, 5, 50};

    logic mclk;
    logic srst;
    wfd_rx_type rx;
    wfd_reg_req_type req;
    logic [15:0] rdata;
    logic wake_irq;
    logic gpio_wake;
    int mismatches;
    int n_compared;
    logic [7:0] fr[$];

    wfd_detector wfd_detector_i (.mclk(mclk), .srst(srst), .rx_in(rx), .reg_req(req),
        .reg_rdata(rdata), .wake_irq(wake_irq), .gpio_wake(gpio_wake));
    wfd_station_model wfd_station_model_i (.mclk(mclk), .rx_out(rx));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        req.wr = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk);
        #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge mclk);
        #1;
        req.rd = 1'b0;
        d = rdata;
    endtask : reg_rd

    // Frame: dst 0 station, 1 broadcast, 2 foreign; pw 0 none, 1 good, 2 bad
    task automatic build(input int dst, input int pre, input int nsync, input int nrep,
                         input int pw);
        fr = {};
        for (int i = 0; i < 6; i++)
        begin
            fr.push_back(dst == 0 ? ST[i] : (dst == 1 ? 8'hff : ST[i] ^ 8'h40));
        end
        for (int i = 0; i < 8 + pre; i++)
        begin
            fr.push_back(i < 6 ? 8'h20 + 8'(i) : 8'h00);
        end
        repeat (nsync) fr.push_back(SYNC_BYTE);
        for (int i = 0; i < 6 * nrep; i++)
        begin
            fr.push_back(ST[i % 6]);
        end
        for (int i = 0; i < 6 && pw > 0; i++)
        begin
            fr.push_back(PW[i] ^ ((pw == 2 && i == 5) ? 8'h01 : 8'h00));
        end
        while (fr.size() < 70) fr.push_back(8'h5a);
    endtask : build

    task automatic run(input string name, input logic [15:0] cfg, input int gap, input bit bad,
                       input logic [15:0] sts, input logic irq, input logic gp);
        logic [15:0] d;
        reg_wr(CFG_ADDR, cfg);
        wfd_station_model_i.send(fr, gap, bad);
        repeat (3) @(posedge mclk);
        #1;
        check({name, " irq"}, {15'h0, wake_irq}, {15'h0, irq});
        check({name, " gpio"}, {15'h0, gpio_wake}, {15'h0, gp});
        reg_rd(STS_ADDR, d);
        check({name, " status"}, d, sts);
        reg_wr(STS_ADDR, S_MAG | S_PAT | S_CRC);
        repeat (2) @(posedge mclk);
        #1;
        check({name, " cleared"}, {14'h0, wake_irq, gpio_wake}, 16'h0000);
        reg_wr(CFG_ADDR, 16'h0000);
        $display("test %s done", name);
    endtask : run

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [15:0] d;
        reg_wr(16'h0200, 16'hffff);
        reg_rd(16'h0200, d);
        check("unmapped", d, 16'h0000);
        reg_rd(BMC_ADDR, d);
        check("control reset", d, BMC_RESET);
        reg_rd(CFG_ADDR, d);
        check("config reset", d, CFG_RESET);
        reg_rd(STS_ADDR, d);
        check("status reset", d, STS_RESET);
        for (int k = 0; k < 3; k++)
        begin
            reg_wr(STATION_ADDR + 16'(k), {ST[2*k+1], ST[2*k]});
            reg_wr(PASSWORD_ADDR + 16'(k), {PW[2*k+1], PW[2*k]});
            reg_rd(PASSWORD_ADDR + 16'(k), d);
            check("password", d, {PW[2*k+1], PW[2*k]});
        end
        $display("test registers done");
    endtask : t_regs

    task automatic t_wake();
        build(0, 3, 6, 16, 0);
        run("unicast", C_MAG | C_UC | C_GP | C_IR, 1, 0, S_MAG, 1, 1);
        run("pin only", C_MAG | C_UC | C_GP, 1, 0, S_MAG, 0, 1);
        run("bad fcs", C_MAG | C_UC | C_GP | C_IR, 1, 1, S_CRC, 0, 0);
        for (int i = 0; i < 3; i++)
        begin
            build(1, i, 7, 16, 0);
            run("rate", C_MAG | C_BC | C_IR, RATE_GAP[i], 0, S_MAG, 1, 0);
        end
    endtask : t_wake

    task automatic t_reject();
        build(0, 2, 5, 16, 0);
        run("short sync", C_MAG | C_UC | C_IR, 1, 0, 16'h0000, 0, 0);
        build(0, 2, 6, 15, 0);
        run("short run", C_MAG | C_UC | C_IR, 1, 0, 16'h0000, 0, 0);
        build(0, 0, 6, 16, 0);
        run("no unicast", C_MAG | C_BC | C_IR, 1, 0, 16'h0000, 0, 0);
        build(1, 0, 6, 16, 0);
        run("no bcast", C_MAG | C_UC | C_IR, 1, 0, 16'h0000, 0, 0);
        build(2, 0, 6, 16, 0);
        run("foreign", C_MAG | C_UC | C_BC | C_IR, 1, 0, 16'h0000, 0, 0);
    endtask : t_reject

    task automatic t_password();
        build(0, 1, 6, 16, 2);
        run("bad pw", C_MAG | C_UC | C_PW | C_IR, 1, 0, 16'h0000, 0, 0);
        build(0, 1, 6, 16, 0);
        run("no pw", C_MAG | C_UC | C_PW | C_IR, 1, 0, 16'h0000, 0, 0);
        build(0, 1, 6, 16, 1);
        run("good pw", C_MAG | C_UC | C_PW | C_IR, 1, 0, S_MAG, 1, 0);
    endtask : t_password

    task automatic t_pattern();
        logic [15:0] d;
        build(0, 0, 0, 0, 0);
        for (int k = 0; k < PATTERN_WORDS; k++)
        begin
            reg_wr(PATTERN_ADDR + 16'(k), {fr[2*k+1], fr[2*k]});
        end
        run("pattern", C_PAT | C_UC | C_GP | C_IR, 2, 0, S_PAT, 1, 1);
        fr[63] = fr[63] ^ 8'h80;
        run("pattern miss", C_PAT | C_UC | C_IR, 1, 0, 16'h0000, 0, 0);
        reg_wr(BMC_ADDR, 16'h1 << BMC_ISOLATE_BIT);
        reg_rd(BMC_ADDR, d);
        check("control write", d, 16'h1 << BMC_ISOLATE_BIT);
        build(0, 0, 6, 16, 0);
        run("isolated", C_MAG | C_UC | C_GP | C_IR, 1, 0, S_MAG, 0, 1);
        reg_wr(BMC_ADDR, 16'h0000);
    endtask : t_pattern

    task automatic close_out();
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        close_out();
    end

    initial
    begin
        srst = 1'b1;
        req = '0;
        mismatches = 0;
        n_compared = 0;
        repeat (6) @(posedge mclk);
        #1;
        srst = 1'b0;
        t_regs();
        t_wake();
        t_reject();
        t_password();
        t_pattern();
        close_out();
    end
endmodule : wfd_detector_tb
